// [hdl/multiqueue_flag_mode_control.sv]
// Flag, status-bus and mode control of a multi-queue flow-control device.
// Assumes one 100 MHz clock; read and write port clocks arrive as one-cycle
// enable pulses (readTick, writeTick) and all inputs are synchronous.
// Per-queue conditions come from queue storage as active-high vectors.
//
// Summary of operation
// RL1: Master-select sampled at full reset sets role
// RL2: Master drives outputs; slaves float after reset
// RL3: Single device: surroundings tie master-select high
// RL4: Full reset is a high-low-high pulse
// RL5: Software programs device after each full reset
// RL6: Master: output enable gates data bus asynchronously
// RL7: Slave: data bus floats until read-selected
// RL8: Near-empty flag low for selected read queue
// RL9: Near-full flag low for selected write queue
// RL10: Read status bus: 8 bits, 16 words
// RL11: Write status bus: 8 bits, 16 words
// RL12: Flag-mode latched at full reset: direct/polled
// RL13: Both status buses can float for sharing
// RL14: Direct: read word chosen by address, strobe
// RL15: Direct: write word chosen by address, strobe (code also requires writeAddressEnable)
// RL16: Polled: read bus steps each read tick
// RL17: Polled: write bus steps each write tick
// RL18: Packet-mode latched at full reset
// RL19: Packet mode: bus shows packet-ready, flag active
// RL20: Near-empty mode: bus near-empty, packet flag idle
// RL21: Packet detection uses writer's start/end marks
// RL22: Packet flag low when complete packet queued
// RL23: Polled sequence wraps after last word
// RL24: Latched modes hold until next full reset
`timescale 1ns/1ps
`include "mq_flag_cfg.svh"

module multiqueue_flag_mode_control
(
    input  wire logic                                     clock,
    input  wire logic                                     rst,
    // Classic Wishbone slave
    input  wire logic                                     wb_cyc_i,
    input  wire logic                                     wb_stb_i,
    input  wire logic                                     wb_we_i,
    input  wire logic [7:0]                               wb_adr_i,
    input  wire logic [31:0]                              wb_dat_i,
    input  wire logic [3:0]                               wb_sel_i,
    output logic      [31:0]                              wb_dat_o,
    output logic                                          wb_ack_o,
    // Straps and reset
    input  wire logic                                     fullResetN,
    input  wire logic                                     primaryRoleSelect,
    input  wire logic                                     packetModeSelect,
    input  wire logic                                     flagModeSelect,
    input  wire logic [2:0]                               deviceId,
    // Read port
    input  wire logic                                     readTick,
    input  wire logic [`MQ_ADDR_BITS-1:0]                 readQueueAddress,
    input  wire logic                                     readAddressEnable,
    input  wire logic                                     readStatusStrobe,
    input  wire logic                                     outputEnableN,
    // Write port
    input  wire logic                                     writeTick,
    input  wire logic [`MQ_ADDR_BITS-1:0]                 writeQueueAddress,
    input  wire logic                                     writeAddressEnable,
    input  wire logic                                     writeStatusStrobe,
    // Per-queue conditions from queue storage, active high
    input  wire logic [`MQ_QUEUE_SLOTS-1:0]               queueNearEmpty,
    input  wire logic [`MQ_QUEUE_SLOTS-1:0]               queueNearFull,
    input  wire logic [`MQ_QUEUE_SLOTS-1:0]               queuePacketReady,
    // Pins, each with its output enable
    output logic                                          dataOutOe,
    output logic                                          nearEmptyFlagN,
    output logic                                          packetAvailFlagN,
    output logic                                          flagOe,
    output logic                                          nearFullFlagN,
    output logic      [`MQ_WORD_BITS-1:0]                 readStatusBus,
    output logic                                          readStatusOe,
    output logic      [`MQ_WORD_BITS-1:0]                 writeStatusBus,
    output logic                                          writeStatusOe
);
    import mq_flag_pkg::*;

    // Picks one 8-bit status word out of a per-queue vector
    function automatic status_word_t wordOf
    (
        input logic [`MQ_QUEUE_SLOTS-1:0] vec,
        input word_idx_t                  idx
    );
        wordOf = vec[idx*`MQ_WORD_BITS +: `MQ_WORD_BITS];
    endfunction

    // True when the device field of an address names this device
    function automatic logic addrIsMine
    (
        input logic [`MQ_ADDR_BITS-1:0] addr,
        input logic [2:0]               id
    );
        addrIsMine = (addr[`MQ_ADDR_BITS-1:`MQ_DEVID_LSB] == id);
    endfunction

    phase_t     phase;           // Held in full reset or running
    logic       isMaster;        // Latched role
    logic       packetMode;      // Latched packet/near-empty mode
    logic       polledMode;      // Latched flag-bus mode
    logic       slaveSelected;   // Slave picked on the read port
    queue_idx_t readQueue;       // Queue selected for reading
    queue_idx_t writeQueue;      // Queue selected for writing
    word_idx_t  readWord;        // Word on the read status bus
    word_idx_t  writeWord;       // Word on the write status bus
    word_idx_t  lastWord;        // Last word of the polled sequence
    logic       ackHeld;         // Registered bus answer

    // Bus decode
    wire        wbReq      = wb_cyc_i & wb_stb_i & ~ackHeld;
    wire        hitCtrl    = (wb_adr_i == `MQ_REG_CTRL);
    wire        hitStatus  = (wb_adr_i == `MQ_REG_STATUS);
    wire        ctrlWrite  = wbReq & wb_we_i & hitCtrl & wb_sel_i[0];

    // Port selections when the device field matches; readOther when it names another device
    wire        readMine   = addrIsMine(readQueueAddress, deviceId);
    wire        writeMine  = addrIsMine(writeQueueAddress, deviceId);
    wire        readSelect = readTick & readAddressEnable & readMine;
    wire        readOther  = readTick & readAddressEnable & ~readMine;
    wire        writeSelect = writeTick & writeAddressEnable & writeMine;
    wire        readPick   = readTick & readStatusStrobe & readMine;
    wire        writePick  = writeTick & writeStatusStrobe & writeAddressEnable & writeMine;

    // Polled sequence successors, wrapping after the last word
    wire        readWrap   = (readWord == lastWord);
    wire        writeWrap  = (writeWord == lastWord);
    wire word_idx_t readNext  = readWrap ? 4'h0 : readWord + 4'h1;   // see RL23
    wire word_idx_t writeNext = writeWrap ? 4'h0 : writeWord + 4'h1; // see RL23

    // Ownership of the shared pins
    wire        running    = (phase == PHASE_RUN);
    wire        owner      = running & (isMaster | slaveSelected);   // see RL2

    // Status word contents, active low on the pins
    wire status_word_t readFlags  = packetMode ? wordOf(queuePacketReady, readWord)
                                               : wordOf(queueNearEmpty, readWord);
    wire status_word_t writeFlags = wordOf(queueNearFull, writeWord);

    // Status register image
    wire [31:0] statusImage = {3'h0, writeQueue, 3'h0, readQueue, writeWord, readWord,
                               4'h0, slaveSelected, polledMode, packetMode, isMaster};

    // Read data for the addressed register; unmapped reads as zero
    wire [31:0] readMux = hitCtrl   ? {28'h0, lastWord} :
                          hitStatus ? statusImage : 32'h0;

    // Phase: held while full reset is low, running after release
    always_ff @(posedge clock)
    begin
        if (rst)
            phase <= PHASE_HELD;
        else if (!fullResetN)                // see RL4
            phase <= PHASE_HELD;
        else
            phase <= PHASE_RUN;
    end

    // Straps are caught while full reset is low, so the value at release wins
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            isMaster   <= 1'b1;
            packetMode <= 1'b0;
            polledMode <= 1'b0;
        end
        else if (!fullResetN)                // Frozen otherwise, see RL24
        begin
            isMaster   <= primaryRoleSelect; // see RL1
            packetMode <= packetModeSelect;  // see RL18
            polledMode <= flagModeSelect;    // see RL12
        end
    end

    // Slave selection follows the last read-port queue pick
    always_ff @(posedge clock)
    begin
        if (rst || !fullResetN)
            slaveSelected <= 1'b0;
        else if (readSelect)                 // see RL7
            slaveSelected <= 1'b1;
        else if (readOther)                  // Another device took the port
            slaveSelected <= 1'b0;
    end

    // Queue selections on each port
    always_ff @(posedge clock)
    begin
        if (rst || !fullResetN)
        begin
            readQueue  <= 5'h00;
            writeQueue <= 5'h00;
        end
        else
        begin
            if (readSelect)
                readQueue <= readQueueAddress[4:0];
            if (writeSelect)
                writeQueue <= writeQueueAddress[4:0];
        end
    end

    // Read status bus word: direct pick or polled step
    always_ff @(posedge clock)
    begin
        if (rst || !fullResetN)
            readWord <= 4'h0;
        else if (polledMode && readTick)     // see RL16
            readWord <= readNext;
        else if (!polledMode && readPick)    // see RL14
            readWord <= readQueueAddress[3:0];
    end

    // Write status bus word: direct pick or polled step
    always_ff @(posedge clock)
    begin
        if (rst || !fullResetN)
            writeWord <= 4'h0;
        else if (polledMode && writeTick)    // see RL17
            writeWord <= writeNext;
        else if (!polledMode && writePick)   // see RL15
            writeWord <= writeQueueAddress[3:0];
    end

    // Status buses load on their own port tick
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            readStatusBus  <= 8'hFF;
            writeStatusBus <= 8'hFF;
        end
        else
        begin
            if (readTick)                    // see RL10, RL19, RL20
                readStatusBus <= ~readFlags;
            if (writeTick)                   // see RL11
                writeStatusBus <= ~writeFlags;
        end
    end

    // Discrete flags, each updated on its own port tick
    always_ff @(posedge clock)
    begin
        if (rst || !fullResetN)
        begin
            nearEmptyFlagN   <= 1'b1;
            packetAvailFlagN <= 1'b1;
            nearFullFlagN    <= 1'b1;
        end
        else
        begin
            if (readTick)
            begin
                nearEmptyFlagN   <= ~queueNearEmpty[{2'b00, readQueue}];      // see RL8
                // Idle high in near-empty mode; marks come from the writer
                packetAvailFlagN <= ~(packetMode &
                                      queuePacketReady[{2'b00, readQueue}]); // see RL21, RL22
            end
            if (writeTick)
                nearFullFlagN <= ~queueNearFull[{2'b00, writeQueue}];         // see RL9
        end
    end

    // Shared pins float unless this device owns them
    always_comb
    begin
        flagOe        = owner;                // see RL2
        readStatusOe  = owner;                // see RL13
        writeStatusOe = owner;                // see RL13
        // Output enable acts without the clock
        dataOutOe     = owner & ~outputEnableN; // see RL6, RL7
    end

    // Control register: last word of the polled sequence, software must set it
    always_ff @(posedge clock)
    begin
        if (rst)
            lastWord <= 4'h3;                // see RL5
        else if (ctrlWrite)
            lastWord <= wb_dat_i[`MQ_CTRL_LAST_MSB:`MQ_CTRL_LAST_LSB];
    end

    // One-cycle answer; ack drops the cycle after it is given
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            ackHeld  <= 1'b0;
            wb_dat_o <= 32'h0;
        end
        else
        begin
            ackHeld  <= wbReq;
            wb_dat_o <= wbReq ? readMux : 32'h0;
        end
    end

    assign wb_ack_o = ackHeld;

endmodule

// [hdl/mq_flag_cfg.svh]
// Constants for the multi-queue flag and mode control block.
// Assumes inclusion by the design module and the test bench only.
`ifndef MQ_FLAG_CFG_SVH
`define MQ_FLAG_CFG_SVH

// Register offsets (byte addresses, one word each)
`define MQ_REG_CTRL        8'h00
`define MQ_REG_STATUS      8'h04

// Control register fields
`define MQ_CTRL_LAST_LSB   0
`define MQ_CTRL_LAST_MSB   3
`define MQ_CTRL_RESET      32'h0000_0003

// Status register field positions
`define MQ_ST_MASTER       0
`define MQ_ST_PACKET       1
`define MQ_ST_POLLED       2
`define MQ_ST_SELECTED     3
`define MQ_ST_RWORD_LSB    8
`define MQ_ST_WWORD_LSB    12
`define MQ_ST_RQUEUE_LSB   16
`define MQ_ST_WQUEUE_LSB   24

// Geometry
`define MQ_WORD_BITS       8
`define MQ_WORD_COUNT      16
`define MQ_QUEUE_SLOTS     128
`define MQ_ADDR_BITS       8
`define MQ_DEVID_LSB       5
`define MQ_DATA_BITS       36

`endif

// [hdl/mq_flag_pkg.sv]
// Types shared by the multi-queue flag and mode control block.
// Assumes the configuration header is compiled alongside.
package mq_flag_pkg;

    // Configuration phase of the device
    typedef enum logic {
        PHASE_HELD,
        PHASE_RUN
    } phase_t;

    typedef logic [3:0] word_idx_t;   // Status word index
    typedef logic [4:0] queue_idx_t;  // Queue within this device
    typedef logic [7:0] status_word_t;

endpackage

// [tb/host_model.sv]
// Far-side host: full reset pulses, straps and per-queue conditions.
// Assumes it shares the block's clock; the bench calls its tasks.
`timescale 1ns/1ps
module host_model
(
    input  wire logic         clock,
    output logic              fullResetN,
    output logic              primaryRoleSelect,
    output logic              packetModeSelect,
    output logic              flagModeSelect,
    output logic [127:0]      queueNearEmpty,
    output logic [127:0]      queueNearFull,
    output logic [127:0]      queuePacketReady
);
    logic [127:0] started;  // Start marker seen per queue

    // Idle host; single device, so the role strap rests high
    initial
    begin
        {fullResetN, primaryRoleSelect, packetModeSelect, flagModeSelect} = 4'hC;
        queueNearEmpty = 128'h0F1E2D3C4B5A69788796A5B4C3D2E1F0;
        queueNearFull = 128'h1122334455667788_99AABBCCDDEEFF00;
        queuePacketReady = '0;
        started = '0;
    end

    // High-low-high pulse; straps flipped after release to prove latching
    task automatic full_reset(input logic [2:0] straps);
        @(posedge clock);
        {primaryRoleSelect, packetModeSelect, flagModeSelect} <= straps;
        fullResetN <= 1'b0;
        repeat (3) @(posedge clock);
        fullResetN <= 1'b1;
        @(posedge clock);
        {primaryRoleSelect, packetModeSelect, flagModeSelect} <= ~straps;
        @(posedge clock);
    endtask

    // Writer marks start then end; complete only once both marks exist
    task automatic write_packet(input int q);
        @(posedge clock);
        started[q] <= 1'b1;
        @(posedge clock);
        queuePacketReady[q] <= started[q];
    endtask
endmodule

// [tb/multiqueue_flag_mode_control_properties.sv]
// Concurrent checks on the flag and mode control block's ports.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
module multiqueue_flag_mode_control_properties
(
    input wire logic         clock, rst, wb_cyc_i, wb_stb_i, wb_ack_o,
    input wire logic [31:0]  wb_dat_o,
    input wire logic         fullResetN, readTick, writeTick, outputEnableN,
    input wire logic [127:0] queuePacketReady,
    input wire logic         dataOutOe, flagOe, readStatusOe, writeStatusOe,
    input wire logic         nearEmptyFlagN, packetAvailFlagN, nearFullFlagN,
    input wire logic [7:0]   readStatusBus, writeStatusBus
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    property p_ack_one; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
    a_ack_one: assert property (p_ack_one) else $error("ack late");
    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
    a_dat_idle: assert property (p_dat_idle) else $error("read data without ack");
    property p_oe_off; outputEnableN |-> !dataOutOe; endproperty
    a_oe_off: assert property (p_oe_off) else $error("data driven while disabled");
    property p_oe_on; flagOe && !outputEnableN |-> dataOutOe; endproperty
    a_oe_on: assert property (p_oe_on) else $error("owner not driving data");
    property p_float_reset; !fullResetN |=> !(flagOe || readStatusOe || writeStatusOe); endproperty
    a_float_reset: assert property (p_float_reset) else $error("pins driven in reset");
    property p_oe_group; readStatusOe == flagOe && writeStatusOe == flagOe; endproperty
    a_oe_group: assert property (p_oe_group) else $error("enables disagree");
    property p_read_hold;
        $past(fullResetN) && !$past(readTick)
            |-> $stable(nearEmptyFlagN) && $stable(packetAvailFlagN) && $stable(readStatusBus);
    endproperty
    a_read_hold: assert property (p_read_hold) else $error("read side moved");
    property p_write_hold;
        $past(fullResetN) && !$past(writeTick) |-> $stable({nearFullFlagN, writeStatusBus});
    endproperty
    a_write_hold: assert property (p_write_hold) else $error("write side moved");
    property p_pr_idle; $past(readTick) && $past(queuePacketReady) == '0 |-> packetAvailFlagN; endproperty
    a_pr_idle: assert property (p_pr_idle) else $error("packet flag without packet");
endmodule

// [tb/test_multiqueue_flag_mode_control.sv]
// Self-checking bench for the flag and mode control block.
// Assumes the host model drives full reset, straps and queue conditions.
`timescale 1ns/1ps
`include "mq_flag_cfg.svh"
module test_multiqueue_flag_mode_control;
    logic         clock, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, readTick, writeTick;
    logic         readAddressEnable, readStatusStrobe, writeAddressEnable, writeStatusStrobe;
    logic         outputEnableN, dataOutOe, nearEmptyFlagN, packetAvailFlagN, flagOe;
    logic         nearFullFlagN, readStatusOe, writeStatusOe, fullResetN;
    logic         primaryRoleSelect, packetModeSelect, flagModeSelect;
    logic [2:0]   deviceId;
    logic [3:0]   wb_sel_i;
    logic [7:0]   wb_adr_i, readQueueAddress, writeQueueAddress, readStatusBus, writeStatusBus;
    logic [31:0]  wb_dat_i, wb_dat_o, rd;
    logic [127:0] queueNearEmpty, queueNearFull, queuePacketReady;
    int           mismatches, n_checks, cycles;

    multiqueue_flag_mode_control i_multiqueue_flag_mode_control (.*);
    host_model i_host (.*);

    // 100 MHz clock
    initial clock = 1'b0;
    always #5 clock = ~clock;

    // Hang guard, well above the hundred or so cycles the tests need
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            mismatches++;
            give_verdict();
        end
    end

    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e)
        begin
            mismatches++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask

    // Classic single cycle; waits for ack, data taken at that edge
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, we, a, d, 4'hF};
        do @(posedge clock); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask

    // One port-clock pulse on the read (wr=0) or write (wr=1) side
    task automatic tick(input logic wr, input logic en, input logic sb, input logic [7:0] a);
        @(posedge clock);
        if (wr)
            {writeTick, writeAddressEnable, writeStatusStrobe, writeQueueAddress} <= {1'b1, en, sb, a};
        else
            {readTick, readAddressEnable, readStatusStrobe, readQueueAddress} <= {1'b1, en, sb, a};
        @(posedge clock);
        {readTick, writeTick} <= 2'b00;
        #1;
    endtask

    task automatic test_packet_direct();
        i_host.full_reset(3'b110);
        wb(1'b0, `MQ_REG_STATUS, 32'h0);
        chk("mode bits", 8'h03, rd[7:0] & 8'h07);
        wb(1'b1, `MQ_REG_CTRL, 32'h3);
        wb(1'b0, 8'h10, 32'h0);
        chk("unmapped", 8'h00, rd[7:0]);
        @(posedge clock);
        outputEnableN <= 1'b0;
        #1;
        chk("data oe", 8'h01, dataOutOe);
        tick(1'b0, 1'b1, 1'b1, 8'h00);
        i_host.write_packet(0);
        tick(1'b0, 1'b0, 1'b0, 8'h00);
        chk("read bus", ~queuePacketReady[7:0], readStatusBus);
        chk("packet flag", 8'h00, packetAvailFlagN);
        tick(1'b0, 1'b1, 1'b0, 8'h04);
        tick(1'b0, 1'b0, 1'b0, 8'h00);
        chk("packet flag", 8'h01, packetAvailFlagN);
        chk("empty flag", !queueNearEmpty[4], nearEmptyFlagN);
        // Queue 11 is near full, so the flag must leave its idle level
        tick(1'b1, 1'b1, 1'b1, 8'h0B);
        tick(1'b1, 1'b0, 1'b0, 8'h00);
        chk("write bus", ~queueNearFull[95:88], writeStatusBus);
        chk("full flag", !queueNearFull[11], nearFullFlagN);
        $display("Test packet direct done");
    endtask

    task automatic test_polled();
        i_host.full_reset(3'b101);
        wb(1'b1, `MQ_REG_CTRL, 32'h3);
        for (int n = 0; n < 6; n++)
        begin
            tick(1'b0, 1'b0, 1'b0, 8'h00);
            tick(1'b1, 1'b0, 1'b0, 8'h00);
            chk("read word", ~queueNearEmpty[(n % 4) * 8 +: 8], readStatusBus);
            chk("write word", ~queueNearFull[(n % 4) * 8 +: 8], writeStatusBus);
        end
        chk("idle packet flag", 8'h01, packetAvailFlagN);
        $display("Test polled done");
    endtask

    task automatic test_slave();
        deviceId <= 3'h2;
        i_host.full_reset(3'b000);
        chk("slave oe", 8'h00, {dataOutOe, flagOe, readStatusOe, writeStatusOe});
        tick(1'b0, 1'b1, 1'b0, 8'h45);
        chk("selected oe", 8'h0F, {dataOutOe, flagOe, readStatusOe, writeStatusOe});
        wb(1'b0, `MQ_REG_STATUS, 32'h0);
        chk("slave status", 8'h08, rd[7:0] & 8'h0F);
        tick(1'b0, 1'b1, 1'b0, 8'h05);
        chk("deselected oe", 8'h00, {dataOutOe, flagOe});
        outputEnableN <= 1'b1;
        $display("Test slave done");
    endtask

    task automatic give_verdict();
        $display("Counts: %0d checks, %0d mismatches", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Reset for 16 cycles, then the scenarios in turn
    initial
    begin
        {rst, outputEnableN, wb_sel_i} = 6'h3F;
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, deviceId} = '0;
        {readTick, readAddressEnable, readStatusStrobe, readQueueAddress} = '0;
        {writeTick, writeAddressEnable, writeStatusStrobe, writeQueueAddress} = '0;
        mismatches = 0;
        n_checks = 0;
        cycles = 0;
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        test_packet_direct();
        test_polled();
        test_slave();
        give_verdict();
    end
endmodule

bind multiqueue_flag_mode_control multiqueue_flag_mode_control_properties i_props (.*);
